// ### verilog/priority_encode_segment_codec.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module priority_encode_segment_codec
	import codec_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic fault_flag
);

	logic [15:0] src_mem [SRC_WORDS];
	logic [15:0] dst_mem [DST_WORDS];
	logic [15:0] dst_calc [DST_WORDS];
	logic [15:0] ctrl_reg;
	logic [4:0] src_base_reg;
	logic [1:0] dst_base_reg;
	cmd_t cmd_reg;
	cmd_t cmd_next;
	state_t state_reg;
	logic fault_reg;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic fault_calc;
	logic fire;
	logic wr_fire;
	logic mapped;
	logic [31:0] rd_mux;

	// address lies in the source area
	function automatic logic in_src(input logic [ADDR_W-1:0] a);
		return a >= SRC_OFFSET;
	endfunction : in_src

	// address lies in the destination window
	function automatic logic in_dst(input logic [ADDR_W-1:0] a);
		return a >= DST_OFFSET && a < DST_OFFSET + 8'h10;
	endfunction : in_dst

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign fault_flag = fault_reg;
	assign cmd_next = cmd_t'(pwdata[3:0]);
	// a transfer completes on the edge where pready is seen high
	assign fire = psel & penable & pready_reg;
	assign wr_fire = fire & pwrite;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		if (in_src(paddr)) begin
			rd_mux = {16'h0000, src_mem[paddr[6:2]]};
		end else if (in_dst(paddr)) begin
			rd_mux = {16'h0000, dst_mem[paddr[3:2]]};
		end else begin
			unique case (paddr)
				CMD_OFFSET: rd_mux = {28'h0, cmd_reg};
				CTRL_OFFSET: rd_mux = {16'h0000, ctrl_reg};
				BASE_OFFSET: rd_mux = {22'h0, dst_base_reg, 3'h0, src_base_reg};
				STATUS_OFFSET: rd_mux = {30'h0, state_reg == ST_EXEC, fault_reg};
				default: mapped = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
			if (psel & penable & ~pready_reg & ~pwrite) begin
				prdata_reg <= rd_mux;
			end else begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
			src_base_reg <= SRC_BASE_RESET;
			dst_base_reg <= DST_BASE_RESET;
			cmd_reg <= CMD_RESET;
		end else if (wr_fire) begin
			if (paddr == CTRL_OFFSET) begin
				ctrl_reg <= pwdata[15:0];
			end
			if (paddr == BASE_OFFSET) begin
				src_base_reg <= pwdata[4:0];
				dst_base_reg <= pwdata[9:8];
			end
			if (paddr == CMD_OFFSET) begin
				cmd_reg <= cmd_next;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < SRC_WORDS; i++) begin
				src_mem[i] <= WORD_RESET;
			end
		end else if (wr_fire && in_src(paddr)) begin
			src_mem[paddr[6:2]] <= pwdata[15:0];
		end
	end

	// op runs only when written with the execution condition on
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (wr_fire && paddr == CMD_OFFSET && cmd_next.exec) begin
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: state_reg <= ST_IDLE;
			endcase
		end
	end

	// flag reflects the last executed op
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fault_reg <= 1'b0;
		end else if (state_reg == ST_EXEC) begin
			fault_reg <= fault_calc;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DST_WORDS; i++) begin
				dst_mem[i] <= WORD_RESET;
			end
		end else if (state_reg == ST_EXEC) begin
			if (!fault_calc) begin
				dst_mem <= dst_calc;
			end
		end else if (wr_fire && in_dst(paddr)) begin
			dst_mem[paddr[3:2]] <= pwdata[15:0];
		end
	end

	always_comb begin
		logic [4:0] sidx;
		logic [1:0] widx;
		logic [2:0] bpos;
		logic [3:0] nib;
		logic [7:0] pos;
		logic found;
		sidx = 5'h00;
		widx = 2'h0;
		bpos = 3'h0;
		nib = 4'h0;
		pos = 8'h00;
		found = 1'b0;
		dst_calc = dst_mem;
		// indirect word flagged by the sequencer
		fault_calc = cmd_reg.indirect_bad;
		unique case (cmd_reg.op)
			OP_PRIO: begin
				if (ctrl_reg[15:12] == MODE_16_TO_4) begin
					if (ctrl_reg[7:6] != 2'h0 || ctrl_reg[3:2] != 2'h0 || ctrl_reg[11:8] != 4'h0) begin
						fault_calc = 1'b1;
					end
					// words must stay inside the area
					if (32'(src_base_reg) + 32'(ctrl_reg[5:4]) >= SRC_WORDS) begin
						fault_calc = 1'b1;
					end
					for (int i = 0; i < 4; i++) begin
						if (i <= int'(ctrl_reg[5:4])) begin
							sidx = src_base_reg + 5'(i);
							widx = ctrl_reg[1:0] + 2'(i);
							if (src_mem[sidx] == 16'h0000) begin
								fault_calc = 1'b1;
							end
							dst_calc[dst_base_reg][{widx, 2'b00} +: 4] = msb16(src_mem[sidx]);
						end
					end
				end else if (ctrl_reg[15:12] == MODE_256_TO_8) begin
					if (ctrl_reg[7:5] != 3'h0 || ctrl_reg[3:1] != 3'h0 || ctrl_reg[11:8] != 4'h0) begin
						fault_calc = 1'b1;
					end
					if (32'(src_base_reg) + GROUP_WORDS * (32'(ctrl_reg[4]) + 32'd1) > SRC_WORDS) begin
						fault_calc = 1'b1;
					end
					for (int g = 0; g < 2; g++) begin
						if (g <= int'(ctrl_reg[4])) begin
							found = 1'b0;
							pos = 8'h00;
							// later words override, leaving the highest
							for (int w = 0; w < GROUP_WORDS; w++) begin
								sidx = src_base_reg + 5'(g * GROUP_WORDS + w);
								if (src_mem[sidx] != 16'h0000) begin
									found = 1'b1;
									pos = {4'(w), msb16(src_mem[sidx])};
								end
							end
							if (!found) begin
								fault_calc = 1'b1;
							end
							// selector 0 right byte, 1 left byte
							bpos = 3'({2'b00, ctrl_reg[0]} + 3'(g));
							dst_calc[dst_base_reg][{bpos[0], 3'b000} +: 8] = pos;
						end
					end
				end else begin
					fault_calc = 1'b1;
				end
			end
			OP_SEG, OP_TEXT: begin
				if (ctrl_reg[11:9] != 3'h0) begin
					fault_calc = 1'b1;
				end
				if (cmd_reg.op == OP_SEG && ctrl_reg[15:12] != 4'h0) begin
					fault_calc = 1'b1;
				end
				if (cmd_reg.op == OP_TEXT && ctrl_reg[15:12] > PAR_ODD) begin
					fault_calc = 1'b1;
				end
				if (32'(dst_base_reg) + (32'(ctrl_reg[8]) + 32'(ctrl_reg[5:4])) / 2 >= DST_WORDS) begin
					fault_calc = 1'b1;
				end
				for (int i = 0; i < 4; i++) begin
					if (i <= int'(ctrl_reg[5:4])) begin
						widx = ctrl_reg[1:0] + 2'(i);
						nib = src_mem[src_base_reg][{widx, 2'b00} +: 4];
						// one byte per code from the chosen half
						bpos = 3'({2'b00, ctrl_reg[8]} + 3'(i));
						widx = dst_base_reg + bpos[2:1];
						if (cmd_reg.op == OP_SEG) begin
							dst_calc[widx][{bpos[0], 3'b000} +: 8] = seg_code(nib);
						end else begin
							dst_calc[widx][{bpos[0], 3'b000} +: 8] = hex_char(nib, ctrl_reg[15:12]);
						end
					end
				end
			end
			default: fault_calc = 1'b1;
		endcase
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_idle_hold(op_kind);
		(wr_fire && paddr == CMD_OFFSET && !cmd_next.exec && cmd_next.op == op_kind
			&& state_reg == ST_IDLE)
			|=> state_reg == ST_IDLE ##1 $stable(dst_mem[0]) && $stable(dst_mem[1])
			&& $stable(dst_mem[2]) && $stable(dst_mem[3]) && $stable(fault_reg);
	endproperty
	a_exec_off_idle: assert property (p_idle_hold(OP_PRIO))
		else $error("op ran with execution condition off");
	a_exec_off_seg: assert property (p_idle_hold(OP_SEG))
		else $error("segment op ran with execution condition off");
	a_prio_digit_value: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_PRIO && ctrl_reg == 16'h0000 && !fault_calc
		|=> dst_mem[$past(dst_base_reg)][3:0] == msb16($past(src_mem[src_base_reg])))
		else $error("16-to-4 digit wrong");
	a_undef_ctrl_fault: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_PRIO && ctrl_reg[15:12] > MODE_256_TO_8
		|=> fault_reg && $stable(dst_mem[0]))
		else $error("undefined control word not flagged");
	a_seg_code_value: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_SEG && ctrl_reg == 16'h0000 && !fault_calc
		|=> dst_mem[$past(dst_base_reg)][7:0] == seg_code($past(src_mem[src_base_reg][3:0])))
		else $error("segment code wrong");
	a_text_no_parity: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_TEXT && ctrl_reg[15:8] == 8'h00 && !fault_calc
		|=> !dst_mem[$past(dst_base_reg)][7])
		else $error("bit 7 set without parity");
	a_text_even_parity: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_TEXT && ctrl_reg[15:8] == 8'h10 && !fault_calc
		|=> ^dst_mem[$past(dst_base_reg)][7:0] == 1'b0)
		else $error("even parity wrong");
	a_text_odd_parity: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_TEXT && ctrl_reg[15:8] == 8'h20 && !fault_calc
		|=> ^dst_mem[$past(dst_base_reg)][7:0] == 1'b1)
		else $error("odd parity wrong");
	a_overrun_fault: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_SEG && dst_base_reg == 2'h3
		&& 3'(ctrl_reg[8]) + 3'(ctrl_reg[5:4]) > 3'h1 |=> fault_reg)
		else $error("destination overrun not flagged");

	// result values
	a_prio_wrap_digit: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_PRIO && ctrl_reg == 16'h0032 && !fault_calc
		|=> dst_mem[$past(dst_base_reg)][3:0] == msb16($past(src_mem[src_base_reg + 5'h02])))
		else $error("16-to-4 wrapped digit wrong");
	a_prio_zero_fault: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_PRIO && ctrl_reg == 16'h0000
		&& src_mem[src_base_reg] == 16'h0000 |=> fault_reg)
		else $error("zero source word not flagged");
	a_prio_byte_kept: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_PRIO && ctrl_reg == 16'h1001 && !fault_calc
		|=> dst_mem[$past(dst_base_reg)][7:0] == $past(dst_mem[dst_base_reg][7:0]))
		else $error("256-to-8 touched the right byte");
	a_seg_wrap_digit: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_SEG && ctrl_reg == 16'h0133 && !fault_calc
		|=> dst_mem[$past(dst_base_reg) + 2'h1][7:0] == seg_code($past(src_mem[src_base_reg][3:0])))
		else $error("segment source digit did not wrap");
	a_seg_bit7_zero: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_SEG && ctrl_reg[11:8] == 4'h0 && !fault_calc
		|=> !dst_mem[$past(dst_base_reg)][7])
		else $error("segment code bit 7 set");
	a_text_char_value: assert property (
		state_reg == ST_EXEC && cmd_reg.op == OP_TEXT && ctrl_reg[11:8] == 4'h0
		&& ctrl_reg[1:0] == 2'h0 && !fault_calc
		|=> dst_mem[$past(dst_base_reg)][6:0] == 7'h30 + 7'($past(src_mem[src_base_reg][3:0]))
			+ (($past(src_mem[src_base_reg][3:0]) > 4'h9) ? 7'h07 : 7'h00))
		else $error("character code wrong");

	// sequencing of an execution
	a_exec_needs_cmd: assert property (
		$rose(state_reg == ST_EXEC) |-> $past(wr_fire && paddr == CMD_OFFSET && cmd_next.exec))
		else $error("op started without a command");
	a_fault_stands: assert property (
		state_reg == ST_IDLE |=> $stable(fault_reg))
		else $error("fault flag changed without an execution");

	c_prio_16: cover property (state_reg == ST_EXEC && cmd_reg.op == OP_PRIO && !fault_calc);
	c_prio_256: cover property (state_reg == ST_EXEC && ctrl_reg[12] && !fault_calc);
	c_seg_wrap: cover property (state_reg == ST_EXEC && cmd_reg.op == OP_SEG && ctrl_reg[5:0] == 6'h33);
	c_text_fault: cover property (state_reg == ST_EXEC && cmd_reg.op == OP_TEXT && fault_calc);
	c_seg_fault: cover property (state_reg == ST_EXEC && cmd_reg.op == OP_SEG && fault_calc);

endmodule : priority_encode_segment_codec
`default_nettype wire

// ### common/codec_pkg.sv
package codec_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] CMD_OFFSET = 8'h00;
	localparam logic [7:0] CTRL_OFFSET = 8'h04;
	localparam logic [7:0] BASE_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0c;
	localparam logic [7:0] DST_OFFSET = 8'h40;
	localparam logic [7:0] SRC_OFFSET = 8'h80;
	localparam int unsigned SRC_WORDS = 32;
	localparam int unsigned DST_WORDS = 4;
	localparam int unsigned GROUP_WORDS = 16;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [4:0] SRC_BASE_RESET = 5'h00;
	localparam logic [1:0] DST_BASE_RESET = 2'h0;
	localparam logic [3:0] MODE_16_TO_4 = 4'h0;
	localparam logic [3:0] MODE_256_TO_8 = 4'h1;
	localparam logic [3:0] PAR_NONE = 4'h0;
	localparam logic [3:0] PAR_EVEN = 4'h1;
	localparam logic [3:0] PAR_ODD = 4'h2;

	typedef enum logic [1:0] {
		OP_PRIO = 2'h0,
		OP_SEG = 2'h1,
		OP_TEXT = 2'h2
	} op_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} state_t;

	typedef struct packed {
		logic indirect_bad;
		logic exec;
		logic [1:0] op;
	} cmd_t;

	localparam cmd_t CMD_RESET = '{indirect_bad: 1'b0, exec: 1'b0, op: 2'h0};

	// number of the highest set bit, zero when none
	function automatic logic [3:0] msb16(input logic [15:0] w);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (w[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : msb16

	// bit 7 blank, bits 6..0 are segments g..a
	function automatic logic [7:0] seg_code(input logic [3:0] n);
		logic [7:0] c;
		unique case (n)
			4'h0: c = 8'h3f;
			4'h1: c = 8'h06;
			4'h2: c = 8'h5b;
			4'h3: c = 8'h4f;
			4'h4: c = 8'h66;
			4'h5: c = 8'h6d;
			4'h6: c = 8'h7d;
			4'h7: c = 8'h27;
			4'h8: c = 8'h7f;
			4'h9: c = 8'h6f;
			4'ha: c = 8'h77;
			4'hb: c = 8'h7c;
			4'hc: c = 8'h39;
			4'hd: c = 8'h5e;
			4'he: c = 8'h79;
			4'hf: c = 8'h71;
		endcase
		return c;
	endfunction : seg_code

	// character code with parity in bit 7
	function automatic logic [7:0] hex_char(input logic [3:0] n, input logic [3:0] par);
		logic [7:0] c;
		c = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
		c[7] = 1'b0;
		if (par == PAR_EVEN) begin
			c[7] = ^c[6:0];
		end else if (par == PAR_ODD) begin
			c[7] = ~^c[6:0];
		end
		return c;
	endfunction : hex_char

endpackage : codec_pkg

// ### sim/seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module seq_model
	import codec_pkg::*;
(
	input wire logic clk_sys,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// one transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show the inverse, not stale values
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : seq_model
`default_nettype wire

// ### sim/tb_priority_encode_segment_codec.sv
`timescale 1ns/1ns
`default_nettype none
module tb_priority_encode_segment_codec
	import codec_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, fault_flag;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	int fails = 0;
	int n_checks = 0;

	always #10 clk_sys = ~clk_sys;

	priority_encode_segment_codec dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fault_flag(fault_flag));
	seq_model bus (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		bus.xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		logic e;
		bus.xfer(1'b0, a, 32'h0, q, e);
		chk(what, exp, q);
		chk("read err", 32'h0, {31'h0, e});
	endtask : rd

	task automatic src(input int i, input logic [15:0] v);
		wr(SRC_OFFSET + 8'(4 * i), {16'h0, v});
	endtask : src

	// cmd nibble: indirect, exec, op
	task automatic run(input logic [3:0] cmd, input logic [15:0] c, input logic [31:0] base,
		input logic f);
		wr(CTRL_OFFSET, {16'h0, c});
		wr(BASE_OFFSET, base);
		wr(CMD_OFFSET, {28'h0, cmd});
		rd(STATUS_OFFSET, {31'h0, f}, "status");
		chk("fault_flag", {31'h0, f}, {31'h0, fault_flag});
	endtask : run

	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end

	initial begin
		logic [31:0] q;
		logic e;
		logic [7:0] seg_tab [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
			8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
		logic [15:0] txt [3] = '{16'h4131, 16'h41b1, 16'hc131};
		logic [15:0] bad_c [6] = '{16'h0004, 16'h0040, 16'h2000, 16'h1002, 16'h0030, 16'h0000};
		logic [31:0] bad_b [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1e, 32'h4};
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(STATUS_OFFSET, 32'h0, "status reset");
		rd(DST_OFFSET, 32'h0, "dst0 reset");
		wr(STATUS_OFFSET, 32'h3);
		rd(STATUS_OFFSET, 32'h0, "status read only");
		bus.xfer(1'b0, 8'h10, 32'h0, q, e);
		chk("unmapped data", 32'h0, q);
		chk("unmapped err", 32'h1, {31'h0, e});
		src(0, 16'h0001);
		src(1, 16'h8000);
		src(2, 16'h0120);
		src(3, 16'h0ff0);
		run(4'h4, 16'h0032, 32'h0, 1'b0);
		rd(DST_OFFSET, 32'h0000f0b8, "encode 16 to 4");
		src(0, 16'h0004);
		wr(CMD_OFFSET, 32'h0);
		rd(DST_OFFSET, 32'h0000f0b8, "exec off");
		for (int i = 0; i < 6; i++) begin
			run(4'h4, bad_c[i], bad_b[i], 1'b1);
			rd(DST_OFFSET, 32'h0000f0b8, "dst after fault");
		end
		run(4'hc, 16'h0000, 32'h0, 1'b1);
		run(4'h4, 16'h0000, 32'h0, 1'b0);
		rd(DST_OFFSET, 32'h0000f0b2, "encode one digit");
		src(9, 16'h0010);
		src(16, 16'h8000);
		run(4'h4, 16'h1010, 32'h100, 1'b0);
		rd(DST_OFFSET + 8'h04, 32'h00000f94, "encode 256 two groups");
		run(4'h4, 16'h1001, 32'h100, 1'b0);
		rd(DST_OFFSET + 8'h04, 32'h00009494, "encode 256 left byte");
		for (int d = 0; d < 16; d++) begin
			src(0, {4{4'(d)}});
			run(4'h5, 16'h0000, 32'h200, 1'b0);
			rd(DST_OFFSET + 8'h08, {24'h0, seg_tab[d]}, "segment code");
		end
		src(0, 16'h4321);
		wr(CMD_OFFSET, 32'h1);
		rd(DST_OFFSET + 8'h08, {24'h0, seg_tab[15]}, "segment exec off");
		run(4'h5, 16'h0133, 32'h100, 1'b0);
		rd(DST_OFFSET + 8'h04, 32'h00006694, "segment dst1");
		rd(DST_OFFSET + 8'h08, 32'h00005b06, "segment dst2");
		rd(DST_OFFSET + 8'h0c, 32'h0000004f, "segment dst3");
		run(4'h5, 16'h0110, 32'h300, 1'b1);
		run(4'h5, 16'h1000, 32'h0, 1'b1);
		rd(DST_OFFSET + 8'h0c, 32'h0000004f, "dst3 after fault");
		src(0, 16'h00a1);
		for (int p = 0; p < 3; p++) begin
			run(4'h6, {4'(p), 12'h010}, 32'h0, 1'b0);
			rd(DST_OFFSET, {16'h0, txt[p]}, "text parity");
		end
		run(4'h6, 16'h3010, 32'h0, 1'b1);
		end_of_test();
	end
endmodule : tb_priority_encode_segment_codec
`default_nettype wire
